// file: tptpcs_framer.sv
// transmit framer, receive deframer, phy control and transmit fifo
// ==========================================================
// fifo between the mac and the transmit framer
module tptpcs_fifo
  import tptpcs_pkg::*;
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
)
(
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic inValid, // write request
  output logic inReady, // room for a word
  input wire logic [WIDTH-1:0] inData, // write data
  output logic outValid, // a word is waiting
  input wire logic outReady, // reader takes the word
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff;
  logic [AW-1:0] rdPtr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic notFull_ff;
  logic push;
  logic pop;

  assign push = inValid && notFull_ff;
  assign pop = outReady && (count_ff != '0);
  assign inReady = notFull_ff;
  assign outValid = (count_ff != '0);
  assign outData = mem[rdPtr_ff];

  // occupancy; ready is kept in a flop so the mac sees a clean level
  always_comb
  begin
    nxt_count = count_ff;
    if (push && !pop)
    begin
      nxt_count = count_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      count_ff <= '0;
      notFull_ff <= 1'b1;
    end
    else
    begin
      count_ff <= nxt_count;
      notFull_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end

  // pointers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop)
      begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wrPtr_ff] <= inData;
    end
  end
endmodule : tptpcs_fifo

// ==========================================================
// top: framer, deframer and phy control
module tptpcs_framer
  import tptpcs_pkg::*;
#( // R20
  parameter logic [9:0] CG_SSD = CG_SSD_DEF, // start delimiter
  parameter logic [9:0] CG_ESD = CG_ESD_DEF, // end delimiter
  parameter logic [9:0] CG_IDLE_OK = CG_IDLE_OK_DEF, // idle, receiver good
  parameter logic [9:0] CG_IDLE_BAD = CG_IDLE_BAD_DEF, // idle, receiver bad
  parameter logic [9:0] CG_ERR = CG_ERR_DEF // transmit error
)
(
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic txValid, // mac word valid
  output logic txReady, // fifo has room
  input wire tptpcs_xgmii_type txWord, // mac transmit word
  input wire logic anComplete, // auto-negotiation done
  input wire logic anLeader, // negotiated role: 1 leader
  input wire logic locRcvrOk, // local receiver reliable
  input wire logic rxCodegroupDelivery, // rx code-groups valid
  input wire tptpcs_quad_type rxCg, // rx groups, index 0..3 = pairs a..d
  output logic [9:0] linePairA, // tx code-group pair a
  output logic [9:0] linePairB, // tx code-group pair b
  output logic [9:0] linePairC, // tx code-group pair c
  output logic [9:0] linePairD, // tx code-group pair d
  output tptpcs_xgmii_type rxWord, // decoded receive word
  output tptpcs_txmode_type txMode, // current transmit mode
  output tptpcs_phyctl_type phyCtlState, // phy control state
  output logic txTimingRecovered, // 1: tx timed by recovered clock
  output logic remRcvrOk // remote receiver reliable
);
  // ==========================================================
  // declarations
  tptpcs_phyctl_type pcState_ff;
  tptpcs_phyctl_type nxt_pcState;
  tptpcs_txmode_type txMode_ff;
  tptpcs_txmode_type nxt_txMode;
  tptpcs_stream_type txState_ff;
  tptpcs_stream_type nxt_txState;
  tptpcs_stream_type rxState_ff;
  tptpcs_stream_type nxt_rxState;
  tptpcs_quad_type txCg_ff;
  tptpcs_quad_type nxt_txCg;
  tptpcs_xgmii_type rxWord_ff;
  tptpcs_xgmii_type nxt_rxWord;
  tptpcs_xgmii_type head;
  logic [35:0] headBits;
  logic headValid;
  logic pop;
  logic follower_ff;
  logic remOk_ff;
  logic nxt_remOk;
  logic [9:0] idleCg;

  assign head = tptpcs_xgmii_type'(headBits);
  assign linePairA = txCg_ff[0];
  assign linePairB = txCg_ff[1];
  assign linePairC = txCg_ff[2];
  assign linePairD = txCg_ff[3];
  assign rxWord = rxWord_ff;
  assign txMode = txMode_ff;
  assign phyCtlState = pcState_ff;
  assign txTimingRecovered = follower_ff;
  assign remRcvrOk = remOk_ff;

  // ==========================================================
  // transmit fifo; the framer stalls it for the delimiter cycle
  tptpcs_fifo #(
    .WIDTH($bits(tptpcs_xgmii_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_txFifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txWord),
    .outValid(headValid),
    .outReady(pop),
    .outData(headBits)
  );

  // ==========================================================
  // phy control: waits for negotiation, trains, then runs
  always_comb
  begin
    nxt_pcState = pcState_ff;
    unique case (pcState_ff)
      PC_DISABLED:
      begin
        if (anComplete)
        begin
          nxt_pcState = PC_TRAINING; // R13
        end
      end
      PC_TRAINING:
      begin
        if (locRcvrOk && remOk_ff)
        begin
          nxt_pcState = PC_RUNNING; // R14
        end
      end
      PC_RUNNING:
      begin
        if (!(locRcvrOk && remOk_ff))
        begin
          nxt_pcState = PC_TRAINING; // R14
        end
      end
      default:
      begin
        nxt_pcState = PC_DISABLED;
      end
    endcase
    if (!anComplete)
    begin
      nxt_pcState = PC_DISABLED; // R13
    end
  end

  // mode follows the next state so mode and state change together
  always_comb
  begin
    unique case (nxt_pcState)
      PC_RUNNING: nxt_txMode = MODE_NORMAL;
      PC_TRAINING: nxt_txMode = MODE_IDLE; // R19
      default: nxt_txMode = MODE_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pcState_ff <= RST_PHYCTL;
      txMode_ff <= RST_MODE;
    end
    else
    begin
      pcState_ff <= nxt_pcState;
      txMode_ff <= nxt_txMode;
    end
  end

  // role is caught when negotiation finishes and held until it restarts;
  // the output steers the transmit clock mux outside this block
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      follower_ff <= 1'b0;
    end
    else if (pcState_ff == PC_DISABLED && anComplete)
    begin
      follower_ff <= !anLeader; // R15 R2 R3
    end
  end

  // ==========================================================
  // transmit framer
  assign idleCg = locRcvrOk ? CG_IDLE_OK : CG_IDLE_BAD; // R7 R16

  always_comb
  begin
    logic termSeen;
    logic [7:0] lane;
    termSeen = 1'b0;
    lane = 8'h00;
    pop = 1'b0;
    nxt_txState = txState_ff;
    nxt_txCg = {NUM_PAIRS{idleCg}}; // R1 R6
    unique case (txMode_ff)
      MODE_ZERO:
      begin
        nxt_txCg = {NUM_PAIRS{CG_ZERO}}; // R18
        pop = headValid;
        nxt_txState = ST_GAP;
      end
      MODE_IDLE:
      begin
        pop = headValid; // R19: mac words are dropped while training
        nxt_txState = ST_GAP;
      end
      MODE_NORMAL:
      begin
        if (txState_ff == ST_GAP)
        begin
          if (headValid && head.ctrl[0] && head.data[7:0] == XG_START)
          begin
            // delimiter takes an extra cycle; the start word stays queued
            nxt_txCg = {NUM_PAIRS{CG_SSD}}; // R4 R8
            nxt_txState = ST_FRAME;
          end
          else
          begin
            pop = headValid; // words outside a frame are not sent
          end
        end
        else if (!headValid)
        begin
          nxt_txCg = {NUM_PAIRS{CG_ERR}}; // R9: mac underran mid-frame
        end
        else
        begin
          pop = 1'b1;
          for (int i = 0; i < NUM_PAIRS; i++)
          begin
            lane = head.data[8*i +: 8];
            if (termSeen)
            begin
              nxt_txCg[i] = idleCg; // R6
            end
            else if (!head.ctrl[i])
            begin
              nxt_txCg[i] = {2'b00, lane}; // R12
            end
            else if (lane == XG_TERM)
            begin
              nxt_txCg[i] = CG_ESD; // R5
              termSeen = 1'b1;
              nxt_txState = ST_GAP;
            end
            else if (i == 0 && lane == XG_START)
            begin
              nxt_txCg[i] = {2'b00, XG_PREAMBLE}; // start lane carries preamble
            end
            else
            begin
              nxt_txCg[i] = CG_ERR; // R9
            end
          end
        end
      end
      default:
      begin
        nxt_txCg = {NUM_PAIRS{CG_ZERO}};
      end
    endcase
  end

  // code-groups leave every cycle on all pairs
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      txState_ff <= ST_GAP;
      txCg_ff <= {NUM_PAIRS{CG_ZERO}};
    end
    else
    begin
      txState_ff <= nxt_txState;
      txCg_ff <= nxt_txCg; // R12
    end
  end

  // ==========================================================
  // receive deframer; the line code is undefined so groups map directly
  always_comb
  begin
    logic endSeen;
    logic [9:0] cg;
    endSeen = 1'b0;
    cg = 10'h000;
    nxt_rxState = rxState_ff;
    nxt_rxWord = XG_IDLE_WORD;
    nxt_remOk = remOk_ff;
    if (rxCodegroupDelivery) // R17
    begin
      if (rxState_ff == ST_GAP)
      begin
        if (rxCg == {NUM_PAIRS{CG_SSD}})
        begin
          nxt_rxWord = '{ctrl: 4'h1, data: {{3{XG_PREAMBLE}}, XG_START}}; // R10
          nxt_rxState = ST_FRAME;
        end
        else
        begin
          for (int i = 0; i < NUM_PAIRS; i++)
          begin
            cg = rxCg[i];
            if (cg != CG_IDLE_OK && cg != CG_IDLE_BAD)
            begin
              nxt_rxWord.data[8*i +: 8] = XG_ERROR; // R11
            end
          end
          if (rxCg == {NUM_PAIRS{CG_IDLE_OK}})
          begin
            nxt_remOk = 1'b1; // R14: remote says its receiver is good
          end
          else if (rxCg == {NUM_PAIRS{CG_IDLE_BAD}})
          begin
            nxt_remOk = 1'b0;
          end
        end
      end
      else
      begin
        for (int i = 0; i < NUM_PAIRS; i++)
        begin
          cg = rxCg[i];
          if (endSeen)
          begin
            nxt_rxWord.data[8*i +: 8] = XG_IDLE;
            nxt_rxWord.ctrl[i] = 1'b1;
          end
          else if (cg == CG_ESD)
          begin
            nxt_rxWord.data[8*i +: 8] = XG_TERM; // R10
            nxt_rxWord.ctrl[i] = 1'b1;
            endSeen = 1'b1;
            nxt_rxState = ST_GAP;
          end
          else if (!cg[CG_CTRL_BIT])
          begin
            nxt_rxWord.data[8*i +: 8] = cg[7:0];
            nxt_rxWord.ctrl[i] = 1'b0;
          end
          else
          begin
            nxt_rxWord.data[8*i +: 8] = XG_ERROR; // R11
            nxt_rxWord.ctrl[i] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rxState_ff <= ST_GAP;
      rxWord_ff <= XG_IDLE_WORD;
      remOk_ff <= 1'b0;
    end
    else
    begin
      rxState_ff <= nxt_rxState;
      rxWord_ff <= nxt_rxWord;
      remOk_ff <= nxt_remOk;
    end
  end
endmodule : tptpcs_framer

// file: tptpcs_pkg.sv
// constants and types shared by the twisted-pair pcs framer
// What this block does
// R1: line never goes quiet; idle code-groups fill every gap between frames. In zero mode (phy control disabled) the code sends CG_ZERO on all pairs.
// R2: as clock leader the transmitter is timed from the local reference clock.
// R3: as clock follower the transmitter is timed from the recovered line clock.
// R4: start character on lane 0 gives a stream start delimiter, then data code-groups.
// R5: terminate character ends the frame with a stream end delimiter.
// R6: idle-mode code-groups follow every stream end delimiter. Code idles only the later lanes; a start delimiter can follow next cycle.
// R7: idle code-groups carry whether the local receiver works reliably.
// R8: every idle-to-data change opens with a stream start delimiter.
// R9: during a frame, distinct code-groups flag transmit errors and other control. The code sends the one CG_ERR for errors and for all other control.
// R10: receive finds frame start and end and decodes into 32-bit words.
// R11: receive reports every bad code-group sequence to the mac. Code forces lanes after an end delimiter to idle unchecked.
// R12: code-groups go out on all four pairs without pause; received ones are processed.
// R13: phy control stays idle until auto-negotiation completes, then runs start-up.
// R14: data mode only while both receivers are reliable, else idle code-groups only.
// R15: leader or follower role comes from auto-negotiation.
// R16: idle mode uses only a small subset of code-groups.
// R17: received code-groups arrive through the code-group delivery strobe.
// R18: transmit mode is normal, idle-only or zeros, followed continuously.
// R19: in training only idle code-groups are generated.
// R20: delimiter, idle and error code-group values are design parameters.
package tptpcs_pkg;
  // ==========================================================
  // widths and sizes
  localparam int NUM_PAIRS = 4;
  localparam int CG_W = 10;
  localparam int CG_CTRL_BIT = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  // ==========================================================
  // mac-side characters, one byte per lane
  localparam logic [7:0] XG_IDLE = 8'h07;
  localparam logic [7:0] XG_START = 8'hfb;
  localparam logic [7:0] XG_TERM = 8'hfd;
  localparam logic [7:0] XG_ERROR = 8'hfe;
  localparam logic [7:0] XG_PREAMBLE = 8'h55;
  // ==========================================================
  // default line code-groups; top bit set marks a control group
  localparam logic [9:0] CG_SSD_DEF = 10'h3c1;
  localparam logic [9:0] CG_ESD_DEF = 10'h3c2;
  localparam logic [9:0] CG_IDLE_OK_DEF = 10'h301;
  localparam logic [9:0] CG_IDLE_BAD_DEF = 10'h302;
  localparam logic [9:0] CG_ERR_DEF = 10'h3fe;
  localparam logic [9:0] CG_ZERO = 10'h000;
  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    MODE_ZERO = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_NORMAL = 2'b10
  } tptpcs_txmode_type;
  typedef enum logic [1:0] {
    PC_DISABLED = 2'b00,
    PC_TRAINING = 2'b01,
    PC_RUNNING = 2'b10
  } tptpcs_phyctl_type;
  typedef enum logic {
    ST_GAP = 1'b0,
    ST_FRAME = 1'b1
  } tptpcs_stream_type;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] ctrl;
    logic [31:0] data;
  } tptpcs_xgmii_type;
  typedef logic [NUM_PAIRS-1:0][CG_W-1:0] tptpcs_quad_type;
  // ==========================================================
  // reset values
  localparam tptpcs_xgmii_type XG_IDLE_WORD = '{ctrl: 4'hf, data: 32'h07070707};
  localparam tptpcs_txmode_type RST_MODE = MODE_ZERO;
  localparam tptpcs_phyctl_type RST_PHYCTL = PC_DISABLED;
endpackage : tptpcs_pkg

// file: tptpcs_framer_asserts.sv
// port-level assertions for the twisted-pair pcs framer
// ==========================================================
// checker
module tptpcs_framer_asserts
  import tptpcs_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic txReady, // fifo has room
  input wire logic anComplete, // negotiation done
  input wire logic anLeader, // negotiated role
  input wire logic locRcvrOk, // local receiver good
  input wire logic rxCodegroupDelivery, // rx groups valid
  input wire tptpcs_quad_type rxCg, // rx groups
  input wire logic [9:0] linePairA, // pair a
  input wire logic [9:0] linePairB, // pair b
  input wire logic [9:0] linePairC, // pair c
  input wire logic [9:0] linePairD, // pair d
  input wire tptpcs_xgmii_type rxWord, // rx word
  input wire tptpcs_txmode_type txMode, // tx mode
  input wire tptpcs_phyctl_type phyCtlState, // control state
  input wire logic txTimingRecovered, // follower timing
  input wire logic remRcvrOk // remote receiver good
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic [39:0] line;
  // all four pairs as one value
  assign line = {linePairD, linePairC, linePairB, linePairA};
  property p_zero_out;
    (phyCtlState == PC_DISABLED) [*3] |-> line == 40'h0;
  endproperty
  a_zero_out: assert property (p_zero_out) else $error("line not zero while disabled");
  property p_mode_map;
    txMode == (phyCtlState == PC_RUNNING ? MODE_NORMAL : phyCtlState == PC_TRAINING ? MODE_IDLE : MODE_ZERO);
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("mode does not follow state");
  // three settled cycles: mode and line are both registered
  property p_idle_status;
    (txMode == MODE_IDLE && $stable(locRcvrOk)) [*3] |-> line == {4{locRcvrOk ? CG_IDLE_OK_DEF : CG_IDLE_BAD_DEF}};
  endproperty
  a_idle_status: assert property (p_idle_status) else $error("wrong idle group");
  property p_an_gate;
    !anComplete |=> phyCtlState == PC_DISABLED;
  endproperty
  a_an_gate: assert property (p_an_gate) else $error("control active without negotiation");
  property p_an_start;
    phyCtlState == PC_DISABLED && anComplete |=> phyCtlState == PC_TRAINING;
  endproperty
  a_an_start: assert property (p_an_start) else $error("start-up not entered");
  property p_role;
    phyCtlState == PC_TRAINING && $past(phyCtlState) == PC_DISABLED |-> txTimingRecovered == !$past(anLeader);
  endproperty
  a_role: assert property (p_role) else $error("timing role not from negotiation");
  property p_run_gate;
    phyCtlState == PC_RUNNING |-> $past(locRcvrOk) && $past(remRcvrOk);
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("running with a bad receiver");
  property p_rx_idle;
    !rxCodegroupDelivery |=> rxWord == XG_IDLE_WORD;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("rx word not idle");
  property p_rx_err;
    rxCodegroupDelivery && rxCg == {4{CG_ERR_DEF}} |=> rxWord == {4'hf, {4{XG_ERROR}}};
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("bad groups not reported");
  property p_rem_ok;
    rxCodegroupDelivery && rxCg == {4{CG_IDLE_OK_DEF}} |=> remRcvrOk;
  endproperty
  a_rem_ok: assert property (p_rem_ok) else $error("remote status not taken");
  c_running: cover property (phyCtlState == PC_RUNNING);
  c_ssd: cover property (line == {4{CG_SSD_DEF}});
  c_full: cover property (!txReady);
  c_rxstart: cover property (rxWord == {4'h1, 32'h555555fb});
endmodule : tptpcs_framer_asserts

bind tptpcs_framer tptpcs_framer_asserts tptpcs_framer_asserts_inst (.clk_sys(clk_sys), .reset(reset),
  .txReady(txReady), .anComplete(anComplete), .anLeader(anLeader), .locRcvrOk(locRcvrOk),
  .rxCodegroupDelivery(rxCodegroupDelivery), .rxCg(rxCg), .linePairA(linePairA), .linePairB(linePairB),
  .linePairC(linePairC), .linePairD(linePairD), .rxWord(rxWord), .txMode(txMode),
  .phyCtlState(phyCtlState), .txTimingRecovered(txTimingRecovered), .remRcvrOk(remRcvrOk));

// file: tptpcs_mac_model.sv
// transmit-side mac model for the pcs framer bench
// ==========================================================
// model
module tptpcs_mac_model
  import tptpcs_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic txReady, // fifo has room
  output logic txValid, // word offered
  output tptpcs_xgmii_type txWord // offered word
);
  timeunit 1ns;
  timeprecision 1ps;
  tptpcs_xgmii_type q[$];
  logic taken = 1'b0;
  initial
  begin
    txValid = 1'b0;
    txWord = XG_IDLE_WORD;
  end
  // frames arrive already marked with start and terminate
  task automatic send(input tptpcs_xgmii_type w);
    q.push_back(w);
  endtask : send
  // a word counts as taken only at the edge that sees ready
  always @(posedge clk_sys)
    taken <= txValid && txReady;
  // offer off the edge; idle data is inverted every cycle so a stale word never looks valid
  always @(negedge clk_sys)
  begin
    if (taken)
      void'(q.pop_front());
    txValid <= q.size() > 0;
    if (q.size() > 0)
      txWord <= q[0];
    else
      txWord <= ~txWord;
  end
endmodule : tptpcs_mac_model

// file: tb_tptpcs_framer.sv
// self-checking bench for the twisted-pair pcs framer
// ==========================================================
// bench
module tb_tptpcs_framer
  import tptpcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [39:0] IDLE4 = {4{CG_IDLE_OK_DEF}};
  localparam logic [39:0] SSD4 = {4{CG_SSD_DEF}};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sawFull = 1'b0;
  logic txValid, txReady, anComplete, anLeader, locRcvrOk, rxCodegroupDelivery;
  logic txTimingRecovered, remRcvrOk;
  logic [9:0] linePairA, linePairB, linePairC, linePairD;
  tptpcs_xgmii_type txWord, rxWord;
  tptpcs_quad_type rxCg, tx;
  tptpcs_txmode_type txMode;
  tptpcs_phyctl_type phyCtlState;
  tptpcs_quad_type expq[$];
  int n_errors = 0;
  int num_checks = 0;
  assign tx = {linePairD, linePairC, linePairB, linePairA};
  always #5 clk_sys = ~clk_sys;
  // remember that the fifo refused at least once
  always @(negedge clk_sys)
    if (!reset && !txReady)
      sawFull = 1'b1;
  tptpcs_mac_model tptpcs_mac_model_inst (.clk_sys(clk_sys), .txReady(txReady), .txValid(txValid), .txWord(txWord));
  tptpcs_framer tptpcs_framer_inst (.clk_sys(clk_sys), .reset(reset), .txValid(txValid), .txReady(txReady),
    .txWord(txWord), .anComplete(anComplete), .anLeader(anLeader), .locRcvrOk(locRcvrOk),
    .rxCodegroupDelivery(rxCodegroupDelivery), .rxCg(rxCg), .linePairA(linePairA), .linePairB(linePairB),
    .linePairC(linePairC), .linePairD(linePairD), .rxWord(rxWord), .txMode(txMode),
    .phyCtlState(phyCtlState), .txTimingRecovered(txTimingRecovered), .remRcvrOk(remRcvrOk));
  // ==========================================================
  // compare and verdict
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic chk_ctl(input logic [1:0] m, input logic [1:0] p, input logic [1:0] f);
    chk({34'h0, txMode, phyCtlState, txTimingRecovered, remRcvrOk}, {34'h0, m, p, f}, "control");
  endtask : chk_ctl
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // ==========================================================
  // transmit expectation: one quad per mac word
  function automatic tptpcs_quad_type enc(input tptpcs_xgmii_type w);
    tptpcs_quad_type q;
    logic [7:0] b;
    bit ended;
    ended = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      b = w.data[8*i+:8];
      if (ended)
        q[i] = CG_IDLE_OK_DEF;
      else if (!w.ctrl[i])
        q[i] = {2'b00, b};
      else if (b == XG_START && i == 0)
        q[i] = {2'b00, XG_PREAMBLE};
      else if (b == XG_TERM)
        q[i] = CG_ESD_DEF;
      else
        q[i] = CG_ERR_DEF;
      ended = ended || (w.ctrl[i] && b == XG_TERM);
    end
    return q;
  endfunction : enc
  // queue one frame: start word, n data words, terminate at lane tl
  task automatic tx_frame(input int n, input int errAt, input int tl);
    tptpcs_xgmii_type w;
    expq.push_back(SSD4);
    for (int i = -1; i <= n; i++)
    begin
      w.data = $urandom;
      w.ctrl = 4'h0;
      if (i < 0)
      begin
        w.ctrl = 4'h1;
        w.data[7:0] = XG_START;
      end
      else if (i == errAt)
      begin
        w.ctrl[1] = 1'b1;
        w.data[15:8] = XG_ERROR;
      end
      else if (i == n)
        for (int j = tl; j < 4; j++)
        begin
          w.ctrl[j] = 1'b1;
          w.data[8*j+:8] = (j == tl) ? XG_TERM : XG_IDLE;
        end
      tptpcs_mac_model_inst.send(w);
      expq.push_back(enc(w));
    end
  endtask : tx_frame
  // walk the line: idle until each delimiter, then cycle-exact
  task automatic tx_check;
    tptpcs_quad_type e;
    int k;
    while (expq.size() > 0)
    begin
      e = expq.pop_front();
      @(negedge clk_sys);
      k = 0;
      while (e === SSD4 && tx !== SSD4 && k < 60)
      begin
        chk(tx, IDLE4, "gap idle");
        @(negedge clk_sys);
        k++;
      end
      chk(tx, e, "line");
    end
  endtask : tx_check
  // ==========================================================
  // receive side
  task automatic rx_put(input tptpcs_quad_type g, input logic [35:0] e, input bit c);
    rxCg = g;
    rxCodegroupDelivery = 1'b1;
    @(negedge clk_sys);
    if (c)
      chk({4'h0, rxWord}, {4'h0, e}, "rx word");
  endtask : rx_put
  task automatic rx_frame(input int n, input int tl);
    tptpcs_quad_type g;
    logic [35:0] e;
    rx_put(SSD4, {4'h1, 32'h555555fb}, 1'b1);
    for (int i = 0; i <= n; i++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        e[8*j+:8] = 8'($urandom);
        e[32+j] = 1'b0;
        g[j] = {2'b00, e[8*j+:8]};
        if (i == n && j >= tl)
        begin
          e[32+j] = 1'b1;
          e[8*j+:8] = (j == tl) ? XG_TERM : XG_IDLE;
          g[j] = (j == tl) ? CG_ESD_DEF : g[j];
        end
        else if (i == 0 && j == 2 && n > 0)
        begin
          e[34] = 1'b1;
          e[23:16] = XG_ERROR;
          g[2] = CG_ERR_DEF;
        end
      end
      rx_put(g, e, 1'b1);
    end
  endtask : rx_frame
  task automatic rx_idle(input bit ok);
    rx_put({4{ok ? CG_IDLE_OK_DEF : CG_IDLE_BAD_DEF}}, 36'h0, 1'b0);
    chk({39'h0, remRcvrOk}, {39'h0, ok}, "remote status");
  endtask : rx_idle
  // ==========================================================
  // main sequence
  initial
  begin
    anComplete = 1'b0;
    anLeader = 1'b0;
    locRcvrOk = 1'b0;
    rxCodegroupDelivery = 1'b0;
    rxCg = '0;
    void'($urandom(2196));
    cyc(10);
    reset = 1'b0;
    chk(tx, 40'h0, "reset line");
    chk({4'h0, rxWord}, {4'h0, XG_IDLE_WORD}, "reset rx");
    chk({39'h0, txReady}, 40'h1, "reset ready");
    chk_ctl(MODE_ZERO, PC_DISABLED, 2'b00);
    $display("test reset done");
    for (int r = 0; r < 2; r++)
    begin
      anLeader = r[0];
      anComplete = 1'b1;
      cyc(3);
      chk_ctl(MODE_IDLE, PC_TRAINING, {~r[0], 1'b0});
      chk(tx, {4{CG_IDLE_BAD_DEF}}, "training idle");
      anComplete = 1'b0;
      cyc(3);
      chk(tx, 40'h0, "zero mode");
    end
    $display("test role done");
    locRcvrOk = 1'b1;
    anLeader = 1'b1;
    anComplete = 1'b1;
    rx_idle(1'b0);
    cyc(2);
    chk_ctl(MODE_IDLE, PC_TRAINING, 2'b00);
    rx_idle(1'b1);
    cyc(2);
    chk_ctl(MODE_NORMAL, PC_RUNNING, 2'b01);
    $display("test start-up done");
    tptpcs_mac_model_inst.send('{ctrl: 4'h0, data: 32'h12345678});
    for (int f = 0; f < 8; f++)
      tx_frame($urandom_range(1, 12), (f % 3 == 1) ? 0 : -1, f % 4);
    tx_check();
    $display("test random frames done");
    for (int f = 0; f < 40; f++)
      tx_frame(0, -1, f % 4);
    tx_check();
    chk({39'h0, sawFull}, 40'h1, "fifo refusal");
    $display("test fifo fill done");
    // the mac stalls inside a frame; the open frame is cut later by retraining
    tptpcs_mac_model_inst.send('{ctrl: 4'h1, data: 32'h000000fb});
    expq.push_back(SSD4);
    expq.push_back(enc('{ctrl: 4'h1, data: 32'h000000fb}));
    expq.push_back({4{CG_ERR_DEF}});
    tx_check();
    $display("test underrun done");
    rx_frame(5, 1);
    rx_frame(0, 0);
    rx_put({4{CG_ERR_DEF}}, {4'hf, {4{XG_ERROR}}}, 1'b1);
    rx_frame($urandom_range(1, 9), 3);
    rx_idle(1'b1);
    $display("test receive done");
    locRcvrOk = 1'b0;
    cyc(4);
    chk_ctl(MODE_IDLE, PC_TRAINING, 2'b01);
    chk(tx, {4{CG_IDLE_BAD_DEF}}, "retrain idle");
    rxCodegroupDelivery = 1'b0;
    rxCg = ~rxCg;
    cyc(2);
    chk({4'h0, rxWord}, {4'h0, XG_IDLE_WORD}, "no delivery");
    $display("test retrain done");
    test_done();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #100us;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule : tb_tptpcs_framer
